// ==== include/dac_params.svh ====
`ifndef DAC_PARAMS_SVH
`define DAC_PARAMS_SVH

// ---------------------------------------------------------------
// Clocking and timing
// ---------------------------------------------------------------
`define DAC_SYS_HZ 200000000
`define DAC_POR_HOLD_NS 1000
`define DAC_CLKOUT_256_HZ 12228000
`define DAC_CLKOUT_384_HZ 18432000
`define DAC_BCK_DIV_256 2
`define DAC_BCK_DIV_384 3
`define DAC_SRC_BCK_HALF 26

// ---------------------------------------------------------------
// Sample rate ranges of the clock recovery
// ---------------------------------------------------------------
`define DAC_FS_LO_MIN_HZ 16000
`define DAC_FS_LO_MAX_HZ 50000
`define DAC_FS_HI_MAX_HZ 100000
`define DAC_PERIOD_SLACK 16'h0010
`define DAC_LOCK_PERIODS 3'h4

// ---------------------------------------------------------------
// Datapath figures
// ---------------------------------------------------------------
`define DAC_OSR_LOG2 6
`define DAC_WORD_BITS 24
`define DAC_DEEMPH_SHIFT 2
`define DAC_GAIN_FULL 9'h100
`define DAC_GAIN_SHIFT 8
`define DAC_SHAPER_ORDER 5
`define DAC_SHAPER_FS 40'sh0000800000

`endif

// ==== include/dac_pkg.sv ====
`include "dac_params.svh"

package dac_pkg;

    // ---------------------------------------------------------------
    // Pin encodings
    // ---------------------------------------------------------------
    // Three-level mode pin seen as two logic bits
    typedef enum logic [1:0] {
        DAC_PLL_LOW = 2'h0,
        DAC_PLL_MID = 2'h1,
        DAC_PLL_HIGH = 2'h3
    } dac_pll_type;

    // Order matches {format_select_hi, format_select_lo}
    typedef enum logic [1:0] {
        DAC_FMT_I2S,
        DAC_FMT_LSB16,
        DAC_FMT_LSB20,
        DAC_FMT_LSB24
    } dac_format_type;

    typedef logic signed [`DAC_WORD_BITS-1:0] dac_sample_type;

    // ---------------------------------------------------------------
    // Derived counts
    // ---------------------------------------------------------------
    // Least time, rounded up
    function automatic int dac_ns_to_cycles(input int ns);
        return int'((longint'(ns) * longint'(`DAC_SYS_HZ) + 64'd999999999) / 64'd1000000000);
    endfunction : dac_ns_to_cycles

    function automatic int dac_period_cycles(input int hz);
        return `DAC_SYS_HZ / hz;
    endfunction : dac_period_cycles

    // Phase step of a 32-bit accumulator for a wanted output rate
    function automatic logic [31:0] dac_nco_step(input int hz);
        return 32'((longint'(hz) << 32) / `DAC_SYS_HZ);
    endfunction : dac_nco_step

endpackage : dac_pkg

// ==== include/dac_link_if.sv ====
interface dac_link_if;
    import dac_pkg::*;

    // Serial audio link, driven by the source
    logic bck;
    logic ws;
    logic serial_audio_in;
    // Strap pins, set by the system around the device
    dac_pll_type pll_mode_tristate;
    logic sysclk_or_range_select;
    logic format_select_hi;
    logic format_select_lo;
    // Shared de-emphasis / clock-out pin
    logic clkout_o;
    logic clkout_oe;
    logic deemph_drive;
    logic deemph_drive_oe;
    logic deemph_or_clock_out;

    // Device drive wins; an undriven pin reads low
    assign deemph_or_clock_out = clkout_oe ? clkout_o : (deemph_drive_oe & deemph_drive);

    modport device (
        input bck, ws, serial_audio_in, pll_mode_tristate, sysclk_or_range_select,
        input format_select_hi, format_select_lo, deemph_or_clock_out,
        output clkout_o, clkout_oe
    );

    modport source (
        input deemph_or_clock_out,
        output bck, ws, serial_audio_in, pll_mode_tristate, sysclk_or_range_select,
        output format_select_hi, format_select_lo, deemph_drive, deemph_drive_oe
    );
endinterface : dac_link_if

// ==== hdl/dac_shaper.sv ====
module dac_shaper (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Sample stream at the oversampled rate
    input wire logic step,
    input wire dac_pkg::dac_sample_type sample,
    // One-bit stream
    output logic bit_out
);
    import dac_pkg::*;

    // ---------------------------------------------------------------
    // Integrator chain with one-bit feedback
    // ---------------------------------------------------------------
    logic signed [39:0] integ [`DAC_SHAPER_ORDER];
    logic signed [39:0] next_integ [`DAC_SHAPER_ORDER];
    logic signed [39:0] feedback;

    // Scaled stages keep the loop bounded for inputs below full scale
    assign feedback = bit_out ? `DAC_SHAPER_FS : -`DAC_SHAPER_FS;

    always_comb begin
        next_integ[0] = integ[0] + 40'(sample) - feedback;
        for (int k = 1; k < `DAC_SHAPER_ORDER; k++) begin
            next_integ[k] = integ[k] + (integ[k-1] >>> 2) - (feedback >>> 2);
        end
    end

    // Update only on the oversampled tick
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < `DAC_SHAPER_ORDER; k++) begin
                integ[k] <= '0;
            end
            bit_out <= 1'b0;
        end else if (step) begin
            integ <= next_integ;
            bit_out <= !next_integ[`DAC_SHAPER_ORDER-1][39];
        end
    end
endmodule : dac_shaper

// ==== hdl/dac_device.sv ====
// Overview of operation
// - Audio mode recovers clocks from word select
// - Video mode runs from fixed reference clock
// - Source slaves its link to clock-out in video
// - Source changes word select on falling edge
// - Half duty word select for LSB formats
// - Low mode pin selects audio mode
// - Range pin picks low or high rates
// - Video mode drives 256 or 384 clock
// - 256 clock covers its listed rates
// - 384 clock covers its listed rates
// - Linear FIR cascade upsamples sixty-four times
// - Fifth-order shaper at sixty-four times rate
// - One-bit stream per channel out
// - Hold internal reset at least 1 us
// - System clock runs during reset
// - Shared pin input in audio, output video
// - Shared pin is range select in audio
// - Format pins choose I2S or LSB widths
// - Bit clock at most 64 word selects
// - De-emphasis pin high enables de-emphasis
// - Mute pin ramps output to silence
module dac_device (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Link to the audio source
    dac_link_if.device link,
    // User side
    input wire logic mute_request,
    output logic pll_locked,
    output logic video_mode,
    output logic deemph_active,
    output logic left_stream,
    output logic right_stream
);
    import dac_pkg::*;

    localparam int POR_CYCLES = dac_ns_to_cycles(`DAC_POR_HOLD_NS);
    localparam int PER_MIN_HI = dac_period_cycles(`DAC_FS_HI_MAX_HZ);
    localparam int PER_MIN_LO = dac_period_cycles(`DAC_FS_LO_MAX_HZ);
    localparam int PER_MAX_LO = dac_period_cycles(`DAC_FS_LO_MIN_HZ);
    localparam logic [31:0] STEP_256 = dac_nco_step(`DAC_CLKOUT_256_HZ);
    localparam logic [31:0] STEP_384 = dac_nco_step(`DAC_CLKOUT_384_HZ);

    // ---------------------------------------------------------------
    // Link domain: reset, format pins, serial receiver
    // ---------------------------------------------------------------
    logic [1:0] bck_rst;
    logic [1:0] fmt_meta;
    logic [1:0] fmt_sync;
    logic ws_d;
    logic [31:0] shreg;
    logic [5:0] bit_idx;
    dac_sample_type i2s_word;
    dac_sample_type left_word;
    dac_sample_type left_hold;
    dac_sample_type right_hold;
    logic frame_tog;
    logic ws_edge;
    logic [4:0] i2s_pos;
    dac_format_type fmt;
    dac_sample_type word_done;

    function automatic dac_sample_type lsb_align(input logic [31:0] sh, input dac_format_type f);
        unique case (f)
            DAC_FMT_LSB16: return {sh[15:0], 8'h00};
            DAC_FMT_LSB20: return {sh[19:0], 4'h0};
            DAC_FMT_LSB24: return sh[23:0];
            DAC_FMT_I2S: return '0;
        endcase
    endfunction : lsb_align

    // Reset released in step with the bit clock
    always_ff @(posedge link.bck or negedge rst_n) begin
        if (!rst_n) begin
            bck_rst <= 2'h0;
            fmt_meta <= 2'h0;
            fmt_sync <= 2'h0;
        end else begin
            bck_rst <= {bck_rst[0], 1'b1};
            fmt_meta <= {link.format_select_hi, link.format_select_lo};
            fmt_sync <= fmt_meta;
        end
    end

    // Inputs launched on falling bck are settled here
    assign ws_edge = link.ws != ws_d;
    assign fmt = dac_format_type'(fmt_sync);
    assign i2s_pos = 5'(`DAC_WORD_BITS - int'(bit_idx));
    assign word_done = fmt == DAC_FMT_I2S ? i2s_word : lsb_align(shreg, fmt);

    // Shift, index and frame capture on the rising bit clock
    always_ff @(posedge link.bck or negedge bck_rst[1]) begin
        if (!bck_rst[1]) begin
            ws_d <= 1'b0;
            shreg <= '0;
            bit_idx <= '0;
            i2s_word <= '0;
            left_word <= '0;
            left_hold <= '0;
            right_hold <= '0;
            frame_tog <= 1'b0;
        end else begin
            ws_d <= link.ws;
            shreg <= {shreg[30:0], link.serial_audio_in};
            if (ws_edge) begin
                bit_idx <= 6'h01;
                i2s_word <= '0;
                if (!ws_d) begin
                    left_word <= word_done;
                end else begin
                    right_hold <= word_done;
                    left_hold <= left_word;
                    frame_tog <= !frame_tog;
                end
            end else begin
                // Saturates at 63 bits a word select half
                bit_idx <= bit_idx == 6'h3f ? bit_idx : bit_idx + 6'h01;
                if (bit_idx != 6'h00 && int'(bit_idx) <= `DAC_WORD_BITS) begin
                    i2s_word[i2s_pos] <= link.serial_audio_in;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // System domain: power-on hold and pin synchronisers
    // ---------------------------------------------------------------
    logic [7:0] por_cnt;
    logic core_ready;
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic ws_last;
    logic tog_last;
    dac_pll_type pll_pin;
    logic range_hi;
    logic new_frame;
    logic ws_rise;

    // Counter needs the system clock running through reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt <= '0;
        end else if (!core_ready) begin
            por_cnt <= por_cnt + 8'h01;
        end
    end
    assign core_ready = por_cnt == 8'(POR_CYCLES);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
            ws_last <= 1'b0;
            tog_last <= 1'b0;
        end else begin
            pin_meta <= {frame_tog, link.ws, link.pll_mode_tristate, link.sysclk_or_range_select,
                link.deemph_or_clock_out};
            pin_sync <= pin_meta;
            ws_last <= pin_sync[4];
            tog_last <= pin_sync[5];
        end
    end

    assign pll_pin = dac_pll_type'(pin_sync[3:2]);
    assign range_hi = !video_mode && pin_sync[1];
    assign new_frame = pin_sync[5] != tog_last;
    assign ws_rise = pin_sync[4] && !ws_last;
    assign deemph_active = !video_mode && pin_sync[0];

    // ---------------------------------------------------------------
    // Mode and clock output
    // ---------------------------------------------------------------
    logic [31:0] nco;
    logic clk_384;
    logic mode_change;

    assign mode_change = (pll_pin != DAC_PLL_LOW) != video_mode || (pll_pin == DAC_PLL_HIGH) != clk_384;

    // Accumulator; jitter is one system period
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            video_mode <= 1'b0;
            clk_384 <= 1'b0;
            nco <= '0;
        end else begin
            video_mode <= pll_pin != DAC_PLL_LOW;
            clk_384 <= pll_pin == DAC_PLL_HIGH;
            nco <= video_mode ? nco + (clk_384 ? STEP_384 : STEP_256) : '0;
        end
    end
    assign link.clkout_o = nco[31];
    assign link.clkout_oe = video_mode;

    // ---------------------------------------------------------------
    // Clock recovery from word select
    // ---------------------------------------------------------------
    logic [15:0] per_cnt;
    logic [15:0] per_last;
    logic [2:0] lock_cnt;
    logic [9:0] tick_cnt;
    logic osr_tick;
    logic per_ok;
    logic per_steady;
    logic [15:0] per_min;
    logic [15:0] per_max;
    logic range_last;

    // Video mode spans all rates
    assign per_min = (range_hi || video_mode) ? 16'(PER_MIN_HI) : 16'(PER_MIN_LO);
    assign per_max = range_hi ? 16'(PER_MIN_LO) : 16'(PER_MAX_LO);
    assign per_ok = per_cnt >= per_min && per_cnt <= per_max;
    assign per_steady = (per_cnt > per_last ? per_cnt - per_last : per_last - per_cnt) <= `DAC_PERIOD_SLACK;
    assign pll_locked = lock_cnt == `DAC_LOCK_PERIODS;
    assign osr_tick = tick_cnt == 10'(per_last >> `DAC_OSR_LOG2);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            per_cnt <= '0;
            per_last <= '0;
            lock_cnt <= '0;
            tick_cnt <= '0;
            range_last <= 1'b0;
        end else begin
            range_last <= range_hi;
            per_cnt <= ws_rise ? 16'h0001 : (per_cnt == 16'hffff ? per_cnt : per_cnt + 16'h0001);
            tick_cnt <= (osr_tick || ws_rise) ? 10'h000 : tick_cnt + 10'h001;
            if (ws_rise) begin
                per_last <= per_cnt;
            end
            if (!core_ready || mode_change || range_hi != range_last || per_cnt == 16'hffff) begin
                lock_cnt <= '0;
            end else if (ws_rise) begin
                lock_cnt <= !(per_ok && per_steady) ? 3'h0 : (pll_locked ? lock_cnt : lock_cnt + 3'h1);
            end
        end
    end

    // ---------------------------------------------------------------
    // Interpolation, de-emphasis, mute and shaping per channel
    // ---------------------------------------------------------------
    logic [5:0] phase;
    logic [8:0] gain;
    dac_sample_type cur [2];
    dac_sample_type prev [2];
    dac_sample_type lin [2];
    dac_sample_type avg [2];
    dac_sample_type emph [2];
    dac_sample_type shaped_in [2];
    logic [1:0] streams;

    function automatic dac_sample_type interp(input dac_sample_type a, input dac_sample_type b,
                                              input logic [5:0] ph);
        logic signed [31:0] diff;
        diff = (32'(b) - 32'(a)) * $signed({26'h0, ph});
        return 24'(32'(a) + (diff >>> `DAC_OSR_LOG2));
    endfunction : interp

    // Ramp to silence when muted or unlocked
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase <= '0;
            gain <= '0;
        end else if (new_frame) begin
            phase <= '0;
        end else if (osr_tick) begin
            phase <= phase == 6'h3f ? phase : phase + 6'h01;
            if (mute_request || !pll_locked) begin
                gain <= gain == 9'h000 ? gain : gain - 9'h001;
            end else begin
                gain <= gain == `DAC_GAIN_FULL ? gain : gain + 9'h001;
            end
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic signed [33:0] scaled;
        assign lin[c] = interp(prev[c], cur[c], phase);
        assign scaled = 34'(emph[c]) * $signed({25'h0, gain});
        assign shaped_in[c] = 24'(scaled >>> `DAC_GAIN_SHIFT);

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                cur[c] <= '0;
                prev[c] <= '0;
                avg[c] <= '0;
                emph[c] <= '0;
            end else begin
                if (new_frame) begin
                    prev[c] <= cur[c];
                    cur[c] <= c == 0 ? left_hold : right_hold;
                end
                if (osr_tick) begin
                    avg[c] <= 24'((25'(lin[c]) + 25'(avg[c])) >>> 1);
                    // One-pole shelf; only active in audio mode
                    emph[c] <= deemph_active ? 24'(emph[c] + ((avg[c] - emph[c]) >>> `DAC_DEEMPH_SHIFT))
                        : avg[c];
                end
            end
        end

        dac_shaper u_shaper (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .step(osr_tick),
            .sample(shaped_in[c]),
            .bit_out(streams[c])
        );
    end

    assign left_stream = streams[0];
    assign right_stream = streams[1];
endmodule : dac_device

// ==== hdl/dac_source.sv ====
module dac_source (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Link to the converter
    dac_link_if.source link,
    // User side: mode and straps
    input wire logic video_select,
    input wire logic clkout_384,
    input wire logic range_hi,
    input wire dac_pkg::dac_format_type format,
    input wire logic deemph_request,
    // User side: samples
    input wire dac_pkg::dac_sample_type left_sample,
    input wire dac_pkg::dac_sample_type right_sample,
    output logic sample_taken
);
    import dac_pkg::*;

    // ---------------------------------------------------------------
    // Straps
    // ---------------------------------------------------------------
    assign link.pll_mode_tristate = !video_select ? DAC_PLL_LOW : (clkout_384 ? DAC_PLL_HIGH : DAC_PLL_MID);
    assign link.sysclk_or_range_select = !video_select && range_hi;
    assign link.format_select_hi = format[1];
    assign link.format_select_lo = format[0];
    assign link.deemph_drive = deemph_request;
    assign link.deemph_drive_oe = !video_select;

    // ---------------------------------------------------------------
    // Bit clock: own divider or clock-out
    // ---------------------------------------------------------------
    logic [2:0] ck_sync;
    logic ck_rise;
    logic step;
    logic [7:0] half;
    logic [7:0] div_cnt;
    logic bck;
    logic bck_fall;
    logic [5:0] slot;
    logic [5:0] next_slot;
    dac_sample_type left_word;
    dac_sample_type right_word;

    function automatic logic src_bit(input dac_sample_type w, input logic [4:0] j, input dac_format_type f);
        int n, k;
        n = f == DAC_FMT_LSB16 ? 16 : (f == DAC_FMT_LSB20 ? 20 : 24);
        k = 31 - int'(j);
        if (f == DAC_FMT_I2S) begin
            return (j != 5'h00 && int'(j) <= `DAC_WORD_BITS) ? w[`DAC_WORD_BITS - int'(j)] : 1'b0;
        end
        return k < n ? w[`DAC_WORD_BITS - n + k] : 1'b0;
    endfunction : src_bit

    // Only the last two stages feed the edge detector
    assign ck_rise = ck_sync[1] && !ck_sync[2];
    assign step = video_select ? ck_rise : 1'b1;
    assign half = !video_select ? 8'(`DAC_SRC_BCK_HALF) : (clkout_384 ? 8'(`DAC_BCK_DIV_384) : 8'(`DAC_BCK_DIV_256));
    assign bck_fall = step && div_cnt == half - 8'h01 && bck;
    assign next_slot = slot + 6'h01;
    assign link.bck = bck;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ck_sync <= '0;
            div_cnt <= '0;
            bck <= 1'b0;
        end else begin
            ck_sync <= {ck_sync[1:0], link.deemph_or_clock_out};
            if (step) begin
                div_cnt <= div_cnt >= half - 8'h01 ? 8'h00 : div_cnt + 8'h01;
                if (div_cnt >= half - 8'h01) begin
                    bck <= !bck;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Frame: 64 slots, ws flips on falling bck
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            slot <= 6'h3f;
            link.ws <= 1'b1;
            link.serial_audio_in <= 1'b0;
            left_word <= '0;
            right_word <= '0;
            sample_taken <= 1'b0;
        end else begin
            sample_taken <= 1'b0;
            if (bck_fall) begin
                slot <= next_slot;
                link.ws <= next_slot[5];
                if (next_slot == 6'h00) begin
                    left_word <= left_sample;
                    right_word <= right_sample;
                    sample_taken <= 1'b1;
                    link.serial_audio_in <= src_bit(left_sample, 5'h00, format);
                end else begin
                    link.serial_audio_in <= src_bit(next_slot[5] ? right_word : left_word, next_slot[4:0], format);
                end
            end
        end
    end
endmodule : dac_source

// ==== tb/dac_link_monitor.sv ====
module dac_link_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Link signals
    input wire logic bck,
    input wire logic ws,
    input wire logic serial_audio_in,
    input wire dac_pkg::dac_pll_type pll_mode_tristate,
    input wire logic clkout_o,
    input wire logic clkout_oe,
    input wire logic deemph_drive_oe
);
    import dac_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [6:0] n_rise;
    logic seen;

    // ---------------------------------------------------------------
    // Bit clocks per word select half
    // ---------------------------------------------------------------
    // A mode change may cut a half short, so the check waits for the next ws edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            n_rise <= 7'h00;
            seen <= 1'b0;
        end else if ($changed(pll_mode_tristate)) begin
            seen <= 1'b0;
        end else if ($changed(ws)) begin
            n_rise <= 7'h00;
            seen <= 1'b1;
        end else if ($rose(bck)) begin
            n_rise <= n_rise + 7'h01;
        end
    end

    // ---------------------------------------------------------------
    // Link checks
    // ---------------------------------------------------------------
    property p_half;
        $changed(ws) && seen |-> n_rise == 7'h20;
    endproperty
    a_half: assert property (p_half) else $error("ws half not 32 bck");
    property p_ws_edge;
        $changed(ws) |-> $fell(bck);
    endproperty
    a_ws_edge: assert property (p_ws_edge) else $error("ws off falling bck");
    property p_data_edge;
        $changed(serial_audio_in) |-> $fell(bck);
    endproperty
    a_data_edge: assert property (p_data_edge) else $error("data off falling bck");
    property p_oe_rise;
        $rose(clkout_oe) |-> pll_mode_tristate != DAC_PLL_LOW;
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("clock out on in audio");
    property p_oe_off;
        (pll_mode_tristate == DAC_PLL_LOW) [*4] |-> !clkout_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe high in audio");
    property p_clk_runs;
        clkout_oe |-> ##[1:20] $changed(clkout_o);
    endproperty
    a_clk_runs: assert property (p_clk_runs) else $error("clock out stalled");
    property p_deemph_oe;
        deemph_drive_oe == (pll_mode_tristate == DAC_PLL_LOW);
    endproperty
    a_deemph_oe: assert property (p_deemph_oe) else $error("source drives pin in video");
    property p_bck_alive;
        1'b1 |-> ##[1:120] $changed(bck);
    endproperty
    a_bck_alive: assert property (p_bck_alive) else $error("bit clock stalled");
endmodule : dac_link_monitor

// ==== tb/audio_dac_clock_and_datapath_tb_top.sv ====
`include "dac_params.svh"
module audio_dac_clock_and_datapath_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dac_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic video_select = 1'b0, clkout_384 = 1'b0, range_hi = 1'b0, deemph_request = 1'b0, mute_request = 1'b0;
    dac_format_type format = DAC_FMT_I2S;
    dac_sample_type left_sample = 24'sh400000;
    dac_sample_type right_sample = 24'shc00000;
    logic pll_locked, video_mode, deemph_active, left_stream, right_stream, sample_taken;
    int n_errors = 0, checks = 0;
    dac_link_if dac_link_if_i ();

    // ---------------------------------------------------------------
    // Ends, monitor and clock
    // ---------------------------------------------------------------
    dac_device dac_device_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(dac_link_if_i.device),
        .mute_request(mute_request),
        .pll_locked(pll_locked), .video_mode(video_mode), .deemph_active(deemph_active),
        .left_stream(left_stream), .right_stream(right_stream));
    dac_source dac_source_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(dac_link_if_i.source),
        .video_select(video_select), .clkout_384(clkout_384), .range_hi(range_hi), .format(format),
        .deemph_request(deemph_request), .left_sample(left_sample), .right_sample(right_sample),
        .sample_taken(sample_taken));
    dac_link_monitor dac_link_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n), .bck(dac_link_if_i.bck),
        .ws(dac_link_if_i.ws), .serial_audio_in(dac_link_if_i.serial_audio_in),
        .pll_mode_tristate(dac_link_if_i.pll_mode_tristate), .clkout_o(dac_link_if_i.clkout_o),
        .clkout_oe(dac_link_if_i.clkout_oe), .deemph_drive_oe(dac_link_if_i.deemph_drive_oe));
    initial forever #2.5 clk_sys = ~clk_sys;

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic check(input logic seen, input logic expected);
        checks++;
        if (seen !== expected) begin
            n_errors++;
            $display("FAIL %0t seen %b expected %b", $time, seen, expected);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    // Bounded; no lock ends the run
    task automatic wait_lock(input int lim);
        int i;
        for (i = 0; i < lim && pll_locked !== 1'b1; i++) step(1);
        if (i == lim) begin
            check(pll_locked, 1'b1);
            tally_and_finish();
        end
    endtask : wait_lock

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    // 3328-cycle frames: high range only
    task automatic t_audio();
        int n = 0, l = 0, r = 0;
        step(14000);
        check(pll_locked, 1'b0);
        check(dac_link_if_i.clkout_oe, 1'b0);
        range_hi = 1'b1;
        wait_lock(30000);
        check(video_mode, 1'b0);
        deemph_request = 1'b1;
        step(8);
        check(deemph_active, 1'b1);
        deemph_request = 1'b0;
        step(8);
        check(deemph_active, 1'b0);
        repeat (6656) begin
            step(1);
            n += sample_taken;
            l += left_stream;
            r += right_stream;
        end
        check(n == 2, 1'b1);
        check(l > r, 1'b1);
        mute_request = 1'b1;
        step(13400);
        l = 0;
        r = 0;
        repeat (3328) begin
            step(1);
            l += left_stream;
            r += right_stream;
        end
        check(l - r < 416 && r - l < 416, 1'b1);
        mute_request = 1'b0;
        for (int f = 0; f < 4; f++) begin
            format = dac_format_type'(f);
            step(2);
            check({dac_link_if_i.format_select_hi, dac_link_if_i.format_select_lo} === 2'(f), 1'b1);
        end
        format = DAC_FMT_I2S;
        $display("test audio done");
    endtask : t_audio
    // Clock-out rises in 10 us
    task automatic t_video(input logic sel, input int rises);
        int n = 0;
        logic p = 1'b0;
        video_select = 1'b1;
        clkout_384 = sel;
        deemph_request = 1'b1;
        step(40);
        check(dac_link_if_i.pll_mode_tristate === (sel ? DAC_PLL_HIGH : DAC_PLL_MID), 1'b1);
        check(video_mode, 1'b1);
        check(deemph_active, 1'b0);
        repeat (2000) begin
            step(1);
            n += dac_link_if_i.clkout_o && !p;
            p = dac_link_if_i.clkout_o;
        end
        check(n >= rises - 2 && n <= rises + 2, 1'b1);
        wait_lock(30000);
        $display("test video done");
    endtask : t_video

    initial begin
        step(12);
        rst_n = 1'b1;
        step(4);
        t_audio();
        t_video(1'b0, `DAC_CLKOUT_256_HZ / 100000);
        t_video(1'b1, `DAC_CLKOUT_384_HZ / 100000);
        tally_and_finish();
    end
endmodule : audio_dac_clock_and_datapath_tb_top
